// file: aso_consts.svh
// timing counts, frame layout and reset levels of the serial output port
`ifndef ASO_CONSTS_SVH
`define ASO_CONSTS_SVH

`define ASO_CLK_NS         50
`define ASO_TCONV60_NS     133000000
`define ASO_TCONV50_NS     160000000
`define ASO_TDOUT_NS       1670000
`define ASO_SCK_DIV        8
`define ASO_FRAME_BITS     32
`define ASO_EXT_CONV_PER   20510
`define ASO_EXT_DOUT_PER   256
`define ASO_EXTOSC_MAX_NS  390625
`define ASO_BIT_EOC        31
`define ASO_BIT_LAST       5'h1F
`define ASO_INIT_WAIT      3'h5
`define ASO_PIN_IDLE_LVL   1'b1
`define ASO_CONV60_CYC     (`ASO_TCONV60_NS / `ASO_CLK_NS)
`define ASO_CONV50_CYC     (`ASO_TCONV50_NS / `ASO_CLK_NS)
`define ASO_OSC_CYC        (`ASO_TDOUT_NS / (`ASO_CLK_NS * `ASO_EXT_DOUT_PER))
`define ASO_EXTOSC_TO_CYC  ((`ASO_EXTOSC_MAX_NS + `ASO_CLK_NS - 1) / `ASO_CLK_NS)

`endif

// file: aso_pkg.sv
// types of the serial output port
package aso_pkg;

    typedef enum logic [1:0] {
        ST_CONVERT,
        ST_SLEEP,
        ST_DOUT
    } aso_state_t;

    typedef struct packed {
        logic        channel_indicator;
        logic        result_sign;
        logic [23:0] value;
        logic [4:0]  subLsb;
    } aso_result_t;

endpackage

// file: aso_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module aso_sync #(
    parameter logic RESET_VAL = 1'b1
)(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pinIn,
    output logic      level
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic nxt_level;

    // s1 is read only by s2
    always_comb
    begin
        nxt_level = level_ff;
        if (s2_ff == s3_ff)
        begin
            nxt_level = s2_ff;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_ff    <= RESET_VAL;
            s2_ff    <= RESET_VAL;
            s3_ff    <= RESET_VAL;
            level_ff <= RESET_VAL;
        end
        else
        begin
            s1_ff    <= pinIn;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

endmodule

`default_nettype wire

// file: aso_serial_port.sv
// conversion-cycle control and serial result output of the converter
`timescale 1ns/1ps
`default_nettype none
`include "aso_consts.svh"

module aso_serial_port
    import aso_pkg::*;
#(
    parameter int unsigned CONV60_CYC    = `ASO_CONV60_CYC,
    parameter int unsigned CONV50_CYC    = `ASO_CONV50_CYC,
    parameter int unsigned EXT_CONV_PER  = `ASO_EXT_CONV_PER,
    parameter int unsigned EXTOSC_TO_CYC = `ASO_EXTOSC_TO_CYC
)(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        csN,
    input  wire logic        sckIn,
    input  wire logic        rejection_freq_select,
    input  wire aso_result_t convResult,
    output logic             sckOut,
    output logic             sckOe,
    output logic             sdo,
    output logic             sdoOe,
    output logic             extSckMode,
    output logic             extOscMode
);

    localparam logic [15:0] OSC_CYC   = 16'(`ASO_OSC_CYC);
    localparam logic [1:0]  HALF_LAST = 2'(`ASO_SCK_DIV / 2 - 1);
    logic       csLvl;
    logic       sckLvl;
    logic       f0Lvl;
    aso_state_t state_ff;
    aso_state_t nxt_state;
    logic [31:0] convCnt_ff;
    logic [31:0] nxt_convCnt;
    logic [31:0] shift_ff;
    logic [31:0] nxt_shift;
    logic [4:0]  bitCnt_ff;
    logic [4:0]  nxt_bitCnt;
    logic [15:0] oscCnt_ff;
    logic [15:0] nxt_oscCnt;
    logic [31:0] oscTo_ff;
    logic [31:0] nxt_oscTo;
    logic        extOsc_ff;
    logic        nxt_extOsc;
    logic [2:0]  initCnt_ff;
    logic [2:0]  nxt_initCnt;
    logic        extMode_ff;
    logic        nxt_extMode;
    logic [1:0]  sckPh_ff;
    logic [1:0]  nxt_sckPh;
    logic        sckOut_ff;
    logic        nxt_sckOut;
    logic        sckOe_ff;
    logic        nxt_sckOe;
    logic        sdo_ff;
    logic        nxt_sdo;
    logic        sdoOe_ff;
    logic        nxt_sdoOe;
    logic        csPrev_ff;
    logic        sckPrev_ff;
    logic        f0Prev_ff;
    logic        csLow;
    logic        csFall;
    logic        csRise;
    logic        f0Rise;
    logic        convTick;
    logic        convInc;
    logic        convDone;
    logic [31:0] convTarget;
    logic        sckRun;
    logic        toggle;
    logic        sckRise;
    logic        sckFall;
    aso_sync #(.RESET_VAL(`ASO_PIN_IDLE_LVL)) uCsSync (
        .clk   (clk),
        .srst  (srst),
        .pinIn (csN),
        .level (csLvl)
    );
    // idle level high so a floating clock pin reads as internal mode
    aso_sync #(.RESET_VAL(`ASO_PIN_IDLE_LVL)) uSckSync (
        .clk   (clk),
        .srst  (srst),
        .pinIn (sckIn),
        .level (sckLvl)
    );
    aso_sync #(.RESET_VAL(1'b0)) uF0Sync (
        .clk   (clk),
        .srst  (srst),
        .pinIn (rejection_freq_select),
        .level (f0Lvl)
    );
    always_comb
    begin
        csLow  = !csLvl;
        csFall = csPrev_ff && !csLvl;
        csRise = !csPrev_ff && csLvl;
        f0Rise = f0Lvl && !f0Prev_ff;

        // external oscillator present while edges keep arriving
        nxt_extOsc = extOsc_ff;
        nxt_oscTo  = oscTo_ff;
        if (f0Lvl != f0Prev_ff)
        begin
            nxt_extOsc = 1'b1;
            nxt_oscTo  = 32'h0;
        end
        else if (oscTo_ff >= EXTOSC_TO_CYC - 1)
        begin
            nxt_extOsc = 1'b0;
        end
        else
        begin
            nxt_oscTo = oscTo_ff + 32'h1;
        end
        nxt_oscCnt = (oscCnt_ff >= OSC_CYC - 16'h1) ? 16'h0
                                                    : oscCnt_ff + 16'h1;
        convTick = extOsc_ff ? f0Rise : (oscCnt_ff >= OSC_CYC - 16'h1);
        // pin strap caught after sync settles, then at each select fall
        nxt_initCnt = initCnt_ff;
        nxt_extMode = extMode_ff;
        if (initCnt_ff != `ASO_INIT_WAIT)
        begin
            nxt_initCnt = initCnt_ff + 3'h1;
            if (initCnt_ff == `ASO_INIT_WAIT - 3'h1)
            begin
                nxt_extMode = !sckLvl;
            end
        end
        else if (csFall)
        begin
            nxt_extMode = !sckLvl;
        end

        // internal clock runs only outside convert with select low
        sckRun = !extMode_ff && csLow && (state_ff != ST_CONVERT);
        toggle = sckRun && convTick && (sckPh_ff == HALF_LAST);
        nxt_sckPh = sckRun ? (convTick ? sckPh_ff + 2'h1 : sckPh_ff) : 2'h0;
        nxt_sckOut = sckRun ? (toggle ? !sckOut_ff : sckOut_ff) : 1'b0;
        nxt_sckOe = !nxt_extMode && csLow;

        // pulses with select high never reach the shifter
        if (extMode_ff)
        begin
            sckRise = csLow && sckLvl && !sckPrev_ff;
            sckFall = csLow && !sckLvl && sckPrev_ff;
        end
        else
        begin
            sckRise = toggle && !sckOut_ff;
            sckFall = toggle && sckOut_ff;
        end

        convTarget = extOsc_ff ? EXT_CONV_PER
                               : (f0Lvl ? CONV50_CYC : CONV60_CYC);
        convInc  = extOsc_ff ? f0Rise : 1'b1;
        // compare as >= so a source change mid-conversion cannot hang it
        convDone = convInc && (convCnt_ff >= convTarget - 32'h1);

        nxt_state   = state_ff;
        nxt_convCnt = convCnt_ff;
        nxt_shift   = shift_ff;
        nxt_bitCnt  = bitCnt_ff;
        case (state_ff)
            ST_CONVERT:
            begin
                if (convDone)
                begin
                    nxt_state   = ST_SLEEP;
                    nxt_convCnt = 32'h0;
                    nxt_shift   = {1'b0, convResult};
                end
                else if (convInc)
                begin
                    nxt_convCnt = convCnt_ff + 32'h1;
                end
            end
            ST_SLEEP:
            begin
                if (csLow && sckRise)
                begin
                    nxt_state  = ST_DOUT;
                    nxt_bitCnt = 5'h0;
                end
            end
            ST_DOUT:
            begin
                if (csRise)
                begin
                    nxt_state   = ST_CONVERT;
                    nxt_convCnt = 32'h0;
                end
                else if (sckFall)
                begin
                    nxt_shift  = {shift_ff[30:0], 1'b0};
                    nxt_bitCnt = bitCnt_ff + 5'h1;
                    if (bitCnt_ff == `ASO_BIT_LAST)
                    begin
                        nxt_state   = ST_CONVERT;
                        nxt_convCnt = 32'h0;
                    end
                end
            end
            default:
            begin
                nxt_state = ST_CONVERT;
            end
        endcase

        // done flag is simply being in convert
        nxt_sdo = (nxt_state == ST_DOUT) ? nxt_shift[`ASO_BIT_EOC]
                                         : (nxt_state == ST_CONVERT);
        nxt_sdoOe = csLow;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff   <= ST_CONVERT;
            convCnt_ff <= 32'h0;
            shift_ff   <= 32'h0;
            bitCnt_ff  <= 5'h0;
            oscCnt_ff  <= 16'h0;
            oscTo_ff   <= 32'h0;
            extOsc_ff  <= 1'b0;
            initCnt_ff <= 3'h0;
            extMode_ff <= 1'b0;
            sckPh_ff   <= 2'h0;
            sckOut_ff  <= 1'b0;
            sckOe_ff   <= 1'b0;
            sdo_ff     <= 1'b1;
            sdoOe_ff   <= 1'b0;
            csPrev_ff  <= 1'b1;
            sckPrev_ff <= 1'b1;
            f0Prev_ff  <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            convCnt_ff <= nxt_convCnt;
            shift_ff   <= nxt_shift;
            bitCnt_ff  <= nxt_bitCnt;
            oscCnt_ff  <= nxt_oscCnt;
            oscTo_ff   <= nxt_oscTo;
            extOsc_ff  <= nxt_extOsc;
            initCnt_ff <= nxt_initCnt;
            extMode_ff <= nxt_extMode;
            sckPh_ff   <= nxt_sckPh;
            sckOut_ff  <= nxt_sckOut;
            sckOe_ff   <= nxt_sckOe;
            sdo_ff     <= nxt_sdo;
            sdoOe_ff   <= nxt_sdoOe;
            csPrev_ff  <= csLvl;
            sckPrev_ff <= sckLvl;
            f0Prev_ff  <= f0Lvl;
        end
    end

    assign sckOut     = sckOut_ff;
    assign sckOe      = sckOe_ff;
    assign sdo        = sdo_ff;
    assign sdoOe      = sdoOe_ff;
    assign extSckMode = extMode_ff;
    assign extOscMode = extOsc_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence lastFall;
        state_ff == ST_DOUT && !csRise && sckFall && bitCnt_ff == 5'h1F;
    endsequence
    sequence newConv;
        state_ff == ST_CONVERT && convCnt_ff == 32'h0;
    endsequence
    a_sdo_hiz: assert property (!csLow |=> !sdoOe_ff)
        else $error("data driver enabled with select high");
    a_eoc_flag: assert property (state_ff != ST_DOUT |->
        sdo_ff == (state_ff == ST_CONVERT))
        else $error("done flag disagrees with state");
    // last fall leaves output, so its flag is checked by a_frame_end
    a_shift_msb: assert property (state_ff == ST_DOUT && !csRise
        && sckFall && bitCnt_ff != 5'h1F |=> sdo_ff == $past(shift_ff[30]))
        else $error("data bit not advanced on falling clock");
    a_int_div: assert property ($rose(sckOut_ff) |->
        $past(sckPh_ff) == 2'h3 && $past(convTick))
        else $error("internal clock not conversion clock over 8");
    a_ext_nodrive: assert property (sckOe_ff |-> !extMode_ff)
        else $error("clock pin driven in external mode");
    a_mode_sel: assert property (initCnt_ff == 3'h5 && csFall
        |=> extMode_ff == !$past(sckLvl))
        else $error("clock mode not taken at select fall");
    a_sleep_hold: assert property (state_ff == ST_SLEEP && !csLow
        |=> state_ff == ST_SLEEP)
        else $error("sleep left with select high");
    a_frame_end: assert property (lastFall |=> newConv ##0 sdo_ff)
        else $error("no new conversion after 32nd falling clock");
    a_abort: assert property (state_ff == ST_DOUT && csRise
        |=> newConv)
        else $error("select rise did not abort output");
    a_shift_hold: assert property (!csLow && state_ff != ST_CONVERT
        |=> $stable(shift_ff))
        else $error("shift register moved with select high");
    a_conv_len: assert property (state_ff == ST_CONVERT && !extOsc_ff
        && nxt_state == ST_SLEEP |->
        convCnt_ff + 32'h1 >= (f0Lvl ? CONV50_CYC : CONV60_CYC))
        else $error("internal conversion ended early");

endmodule

`default_nettype wire

// file: aso_host_model.sv
// host controller model driving the serial port pins
`timescale 1ns/1ps
`default_nettype none

module aso_host_model (
    input  wire logic clk,
    input  wire logic sckPin,
    input  wire logic sdoPin,
    output logic      csN,
    output logic      hostSck,
    output logic      hostOe
);
    initial
    begin
        csN = 1'b1;
        hostSck = 1'b0;
        hostOe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cs(input logic v);
        tick(1);
        csN = v;
    endtask

    // held low over a select fall picks external clock mode
    task automatic drv(input logic oe);
        tick(1);
        hostOe = oe;
        hostSck = 1'b0;
    endtask

    // phases of 6 clk so the 3-flop sync never misses one
    task automatic frame(input int n, output logic [31:0] d);
        d = '0;
        for (int i = 0; i < n; i++)
        begin
            tick(6);
            d = {d[30:0], sdoPin};
            hostSck = 1'b1;
            tick(6);
            hostSck = 1'b0;
        end
        tick(6);
    endtask

    // passive capture while the device drives the clock
    task automatic iframe(output logic [31:0] d, output int per);
        realtime t0;
        d = '0;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge sckPin);
            #1;
            d = {d[30:0], sdoPin};
            if (i == 0) t0 = $realtime;
            if (i == 1) per = int'(($realtime - t0) / 50.0);
        end
    endtask
endmodule

`default_nettype wire

// file: tb.sv
// self-checking bench of the serial output port
`timescale 1ns/1ps
`default_nettype none

module tb;
    import aso_pkg::*;
    logic        clk;
    logic        srst;
    logic        rfs;
    logic        rfsSet;
    logic        oscLvl;
    logic        oscOn;
    aso_result_t res;
    wire logic   csN;
    wire logic   hostSck;
    wire logic   hostOe;
    wire logic   sckIn;
    wire logic   sdoPin;
    logic        sckOut;
    logic        sckOe;
    logic        sdo;
    logic        sdoOe;
    logic        extSckMode;
    logic        extOscMode;
    int          bad_count;
    int          total_checks;
    logic [31:0] d;
    int          n;

    // pull-up on the clock pin when nobody drives it
    assign sckIn = sckOe ? sckOut : (hostOe ? hostSck : 1'b1);
    // released data line shows the inverse so stale bits cannot pass
    assign sdoPin = sdoOe ? sdo : ~sdo;

    aso_serial_port #(
        .CONV60_CYC   (200),
        .CONV50_CYC   (300),
        .EXT_CONV_PER (20),
        .EXTOSC_TO_CYC(100)
    ) DUT (
        .clk                  (clk),
        .srst                 (srst),
        .csN                  (csN),
        .sckIn                (sckIn),
        .rejection_freq_select(rfs),
        .convResult           (res),
        .sckOut               (sckOut),
        .sckOe                (sckOe),
        .sdo                  (sdo),
        .sdoOe                (sdoOe),
        .extSckMode           (extSckMode),
        .extOscMode           (extOscMode)
    );

    aso_host_model host (
        .clk    (clk),
        .sckPin (sckIn),
        .sdoPin (sdoPin),
        .csN    (csN),
        .hostSck(hostSck),
        .hostOe (hostOe)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // free oscillator of 20 clk period, routed to the rejection frequency select pin on demand
    assign rfs = oscOn ? oscLvl : rfsSet;
    always
    begin
        repeat (10) @(negedge clk);
        oscLvl = ~oscLvl;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        total_checks++;
        if (g < lo || g > hi)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    // cycles until the done flag drops, bounded
    task automatic wt(output int c);
        c = 0;
        while (sdoPin !== 1'b0 && c < 3000)
        begin
            @(negedge clk);
            c++;
        end
    endtask

    initial
    begin
        #3000000;
        bad_count++;
        test_done();
    end

    initial
    begin
        bad_count = 0;
        total_checks = 0;
        srst = 1'b1;
        rfsSet = 1'b0;
        oscLvl = 1'b0;
        oscOn = 1'b0;
        res = 31'h2B4B_87D3;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        host.tick(10);
        chk("extSckMode", 32'h0, extSckMode);
        chk("sdoOe", 32'h0, sdoOe);
        host.drv(1'b1);
        host.tick(6);
        host.cs(1'b0);
        host.tick(8);
        chk("extSckMode", 32'h1, extSckMode);
        chk("sckOe", 32'h0, sckOe);
        chk("sdo", 32'h1, sdoPin);
        wt(n);
        chk("sdo", 32'h0, sdoPin);
        host.frame(32, d);
        chk("frame", {1'b0, res}, d);
        chk("sdo", 32'h1, sdoPin);
        wt(n);
        chk_rng("conv60", 190, 205, n);
        rfsSet = 1'b1;
        host.frame(32, d);
        wt(n);
        chk_rng("conv50", 290, 305, n);
        rfsSet = 1'b0;
        host.cs(1'b1);
        host.tick(350);
        chk("sdoOe", 32'h0, sdoOe);
        host.frame(3, d);
        res = ~res;
        host.cs(1'b0);
        host.tick(8);
        chk("sdo", 32'h0, sdoPin);
        host.frame(32, d);
        chk("frame", {1'b0, ~res}, d);
        wt(n);
        host.frame(5, d);
        chk("part", {27'h0, 1'b0, res[30:27]}, d);
        host.cs(1'b1);
        host.tick(8);
        host.cs(1'b0);
        host.tick(8);
        chk("sdo", 32'h1, sdoPin);
        oscOn = 1'b1;
        wt(n);
        host.frame(32, d);
        wt(n);
        chk_rng("convExt", 380, 420, n);
        chk("extOscMode", 32'h1, extOscMode);
        oscOn = 1'b0;
        host.tick(150);
        chk("extOscMode", 32'h0, extOscMode);
        host.cs(1'b1);
        host.drv(1'b0);
        host.tick(400);
        host.cs(1'b0);
        host.tick(8);
        chk("extSckMode", 32'h0, extSckMode);
        chk("sckOe", 32'h1, sckOe);
        host.iframe(d, n);
        chk("frame", {1'b0, res}, d);
        chk_rng("sckPeriod", 1040, 1040, n);
        test_done();
    end
endmodule

`default_nettype wire
